// ===== hw/afst_defs.svh
`ifndef AFST_DEFS_SVH
`define AFST_DEFS_SVH

// Register offsets
`define AFST_ADDR_STATUS 8'h00
`define AFST_ADDR_TRIG 8'h0A

// Buffer status fields
`define AFST_OVF_BIT 7
`define AFST_WMRK_BIT 6
`define AFST_CNT_HI 5
`define AFST_CNT_LO 0

// Ordinary data status fields
`define AFST_XDR_BIT 0
`define AFST_YDR_BIT 1
`define AFST_ZDR_BIT 2
`define AFST_ZYXDR_BIT 3

// Trigger select fields
`define AFST_TRIG_HI 5
`define AFST_TRIG_LO 1

// Reset values
`define AFST_BYTE_RST 8'h00
`define AFST_FLAG_RST 1'h0

// Fixed figures
`define AFST_DEPTH 32
`define AFST_SAMPLE_W 42
`define AFST_EVT_W 5

`endif

// ===== hw/afst_pkg.sv
package afst_pkg;

  // Buffer mode, order matches the two-bit mode field
  typedef enum logic [1:0] {
    AFST_MODE_OFF,
    AFST_MODE_CIRC,
    AFST_MODE_STOP,
    AFST_MODE_TRIG
  } afst_mode_t;

  typedef logic [7:0] afst_byte_t;

endpackage : afst_pkg

// ===== hw/afst_top.sv
// Behaviour
// - Y ready flag sets, clears on Y read
// - X ready flag sets, clears on X read
// - Z ready flag sets, clears on Z read
// - Address 0x00 shows buffer status when enabled
// - Status: overflow b7, watermark b6, count
// - Count reads zero when buffer empty
// - Count one to thirty-two means stored samples
// - Overflow flag reads one after overflow
// - Overflow stays while buffer stays overflowed
// - Watermark flag asserts at watermark count
// - Watermark flag holds while count above watermark
// - Trigger mode: bit six means trigger seen
// - Status read clears buffer interrupt bit
// - Interrupt sets again on next stored sample leaving count at or above watermark
// - Interrupt on overflow, trigger, or stored sample leaving count at or above watermark
// - Enabled trigger event freezes the buffer
// - Frozen buffer keeps pre-event samples
// - Select bit five enables transient trigger
// - Select bits four to one enable triggers
`timescale 1ns/1ns
`include "afst_defs.svh"

module afst_fifo #(
  parameter int WIDTH = `AFST_SAMPLE_W,
  parameter int DEPTH = `AFST_DEPTH,
  parameter int CW = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [CW-1:0] count
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } afst_fifo_state_t;

  afst_fifo_state_t s_reg;
  afst_fifo_state_t s_next;
  logic push;
  logic pop;

  assign out_valid = s_reg.count != '0;
  assign pop = out_valid & out_ready;
  assign in_ready = (s_reg.count != FULL) | pop;
  assign push = in_valid & in_ready;
  assign out_data = s_reg.mem[s_reg.rd_ptr];
  assign count = s_reg.count;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wr_ptr] = in_data;
      s_next.wr_ptr = (s_reg.wr_ptr == LAST) ? '0 : s_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      s_next.rd_ptr = (s_reg.rd_ptr == LAST) ? '0 : s_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      s_next.count = s_reg.count + 1'b1;
    end else if (pop && !push) begin
      s_next.count = s_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : afst_fifo

module afst_top #(
  parameter int WIDTH = `AFST_SAMPLE_W,
  parameter int DEPTH = `AFST_DEPTH,
  parameter int CW = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register access
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Buffer setup
  input wire logic [1:0] buf_mode,
  input wire logic [CW-1:0] watermark,
  // Axis acquisition and high byte reads
  input wire logic x_done,
  input wire logic y_done,
  input wire logic z_done,
  input wire logic x_msb_read,
  input wire logic y_msb_read,
  input wire logic z_msb_read,
  // Sample stream
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [WIDTH-1:0] sample_data,
  // Event flags: transient, orientation, pulse, freefall, magnitude
  input wire logic [`AFST_EVT_W-1:0] evt_flags,
  // Drain to host
  output logic drain_valid,
  input wire logic drain_ready,
  output logic [WIDTH-1:0] drain_data,
  // Status outputs
  output logic buf_irq,
  output logic buf_frozen
);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    afst_pkg::afst_byte_t trig_cfg;
    afst_pkg::afst_byte_t rdata;
    logic xdr;
    logic ydr;
    logic zdr;
    logic ovf;
    logic frozen;
    logic src_fifo;
  } afst_state_t;

  afst_state_t s_reg;
  afst_state_t s_next;
  afst_pkg::afst_mode_t mode;
  logic enabled;
  logic trig_hit;
  logic freeze_now;
  logic full;
  logic push_req;
  logic overflow_evt;
  logic discard;
  logic f_in_ready;
  logic f_out_valid;
  logic pushed;
  logic popped;
  logic [CW-1:0] f_count;
  logic [CW-1:0] cnt_next;
  logic wm_flag;
  logic status_rd;
  afst_pkg::afst_byte_t status_val;

  assign mode = afst_pkg::afst_mode_t'(buf_mode);
  assign enabled = mode != afst_pkg::AFST_MODE_OFF;
  assign trig_hit = (mode == afst_pkg::AFST_MODE_TRIG) &&
    |(evt_flags & s_reg.trig_cfg[`AFST_TRIG_HI:`AFST_TRIG_LO]);
  assign freeze_now = s_reg.frozen | trig_hit;
  assign full = f_count == FULL;
  assign push_req = sample_valid & enabled & ~freeze_now;
  assign overflow_evt = push_req & full;
  assign discard = overflow_evt & (mode != afst_pkg::AFST_MODE_STOP);
  assign pushed = push_req & f_in_ready;
  assign popped = f_out_valid & (drain_ready | discard);
  assign cnt_next = f_count + CW'(pushed) - CW'(popped);
  assign sample_ready = f_in_ready;
  assign drain_valid = f_out_valid;
  assign buf_irq = s_reg.src_fifo;
  assign buf_frozen = s_reg.frozen;
  assign reg_rdata = s_reg.rdata;
  assign status_rd = reg_rd && (reg_addr == `AFST_ADDR_STATUS);

  afst_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH),
    .CW(CW)
  ) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .in_valid(push_req),
    .in_ready(f_in_ready),
    .in_data(sample_data),
    .out_valid(f_out_valid),
    .out_ready(drain_ready | discard),
    .out_data(drain_data),
    .count(f_count)
  );

  // Watermark and hold and trigger meaning
  assign wm_flag = (mode == afst_pkg::AFST_MODE_TRIG) ? s_reg.frozen :
    ((watermark != '0) && (f_count >= watermark));

  // Status view and layout and empty and count
  always_comb begin
    status_val = `AFST_BYTE_RST;
    if (enabled) begin
      status_val[`AFST_OVF_BIT] = s_reg.ovf;
      status_val[`AFST_WMRK_BIT] = wm_flag;
      status_val[`AFST_CNT_HI:`AFST_CNT_LO] = 6'(f_count);
    end else begin
      status_val[`AFST_XDR_BIT] = s_reg.xdr;
      status_val[`AFST_YDR_BIT] = s_reg.ydr;
      status_val[`AFST_ZDR_BIT] = s_reg.zdr;
      status_val[`AFST_ZYXDR_BIT] = s_reg.xdr | s_reg.ydr | s_reg.zdr;
    end
  end

  always_comb begin
    s_next = s_reg;
    // Y flag and X flag and Z flag
    s_next.xdr = x_done | (s_reg.xdr & ~x_msb_read);
    s_next.ydr = y_done | (s_reg.ydr & ~y_msb_read);
    s_next.zdr = z_done | (s_reg.zdr & ~z_msb_read);
    // Overflow set and hold while full
    if (!enabled) begin
      s_next.ovf = `AFST_FLAG_RST;
    end else if (overflow_evt) begin
      s_next.ovf = 1'b1;
    end else if (cnt_next != FULL) begin
      s_next.ovf = `AFST_FLAG_RST;
    end
    if (mode != afst_pkg::AFST_MODE_TRIG) begin
      s_next.frozen = `AFST_FLAG_RST;
    end else if (trig_hit) begin
      s_next.frozen = 1'b1;
    end
    // Read clears and re-set and sources
    if (overflow_evt || (trig_hit && !s_reg.frozen) ||
        (pushed && (watermark != '0) && (cnt_next >= watermark))) begin
      s_next.src_fifo = 1'b1;
    end else if (status_rd) begin
      s_next.src_fifo = `AFST_FLAG_RST;
    end
    if (reg_wr && reg_addr == `AFST_ADDR_TRIG) begin
      s_next.trig_cfg = reg_wdata;
    end
    if (reg_rd) begin
      case (reg_addr)
        `AFST_ADDR_STATUS: s_next.rdata = status_val;
        `AFST_ADDR_TRIG: s_next.rdata = s_reg.trig_cfg;
        default: s_next.rdata = `AFST_BYTE_RST;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  ydr_set_a: assert property (y_done |=> s_reg.ydr)
    else $error("Y ready flag not set");
  ydr_clear_a: assert property (y_msb_read && !y_done |=> !s_reg.ydr)
    else $error("Y ready flag not cleared");
  xdr_clear_a: assert property (x_msb_read && !x_done |=> !s_reg.xdr)
    else $error("X ready flag not cleared");
  xdr_set_a: assert property (x_done |=> s_reg.xdr)
    else $error("X ready flag not set");
  zdr_set_a: assert property (z_done |=> s_reg.zdr)
    else $error("Z ready flag not set");
  zdr_clear_a: assert property (z_msb_read && !z_done |=> !s_reg.zdr)
    else $error("Z ready flag not cleared");
  status_view_a: assert property (status_rd && enabled |=>
    reg_rdata[`AFST_CNT_HI:`AFST_CNT_LO] == 6'($past(f_count)))
    else $error("Status read shows wrong count");
  ovf_bit_a: assert property (status_rd && enabled |=>
    reg_rdata[`AFST_OVF_BIT] == $past(s_reg.ovf))
    else $error("Overflow bit wrong in status");
  empty_cnt_a: assert property (status_rd && enabled && f_count == '0
    |=> reg_rdata[`AFST_CNT_HI:`AFST_CNT_LO] == 6'h00)
    else $error("Empty buffer count not zero");
  count_max_a: assert property (f_count <= FULL)
    else $error("Count above depth");
  ovf_set_a: assert property (overflow_evt |=> s_reg.ovf)
    else $error("Overflow flag not set");
  ovf_hold_a: assert property (s_reg.ovf && full && enabled && !popped
    |=> s_reg.ovf)
    else $error("Overflow flag dropped while full");
  wm_level_a: assert property (status_rd && enabled && watermark != '0 &&
    mode != afst_pkg::AFST_MODE_TRIG && f_count >= watermark
    |=> reg_rdata[`AFST_WMRK_BIT])
    else $error("Watermark flag missing");
  trig_bit_a: assert property (status_rd && mode == afst_pkg::AFST_MODE_TRIG
    |=> reg_rdata[`AFST_WMRK_BIT] == $past(buf_frozen))
    else $error("Trigger flag wrong in status");
  irq_clear_a: assert property (status_rd && !overflow_evt && !pushed &&
    !trig_hit |=> !buf_irq)
    else $error("Status read did not clear interrupt");
  irq_again_a: assert property (pushed && watermark != '0 |=>
    buf_irq || f_count < $past(watermark))
    else $error("Interrupt not set again on stored sample");
  irq_ovf_a: assert property (overflow_evt |=> buf_irq)
    else $error("Overflow did not raise interrupt");
  frozen_hold_a: assert property (s_reg.frozen |=>
    f_count <= $past(f_count))
    else $error("Sample stored while frozen");
  trig_freeze_a: assert property (trig_hit |=> buf_frozen ##1
    (buf_frozen || $past(mode) != afst_pkg::AFST_MODE_TRIG))
    else $error("Trigger did not freeze buffer");
  trig_trans_a: assert property (mode == afst_pkg::AFST_MODE_TRIG &&
    evt_flags[`AFST_EVT_W-1] && s_reg.trig_cfg[`AFST_TRIG_HI] |=>
    buf_frozen)
    else $error("Transient trigger did not freeze buffer");
  trig_off_a: assert property (mode == afst_pkg::AFST_MODE_TRIG &&
    !s_reg.frozen && evt_flags[0] && !(|evt_flags[`AFST_EVT_W-1:1]) &&
    !s_reg.trig_cfg[`AFST_TRIG_LO] |=> !buf_frozen)
    else $error("Disabled trigger source froze buffer");
  ovf_full_a: assert property (overflow_evt |=> f_count == FULL)
    else $error("Buffer not full after overflow");

  fill_c: cover property (pushed ##1 f_count == FULL);
  ovf_c: cover property (overflow_evt ##1 s_reg.ovf);
  trig_c: cover property (trig_hit ##1 buf_frozen ##1 popped);
  rd_clear_c: cover property (buf_irq ##1 status_rd ##1 !buf_irq);
  stop_c: cover property (mode == afst_pkg::AFST_MODE_STOP &&
    overflow_evt ##1 s_reg.ovf);
endmodule : afst_top

// ===== verification/afst_host_model.sv
`timescale 1ns/1ns

module afst_host_model (
  // Clock
  input wire logic clock,
  // Register access
  output logic reg_rd,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Drain side
  output logic drain_ready,
  input wire logic [41:0] drain_data
);
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    drain_ready = 1'b0;
  end

  // Write strobe held one edge
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Data is registered at the strobe edge
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  // Head word taken before the popping edge
  task automatic pop(output logic [41:0] d);
    @(posedge clock);
    drain_ready <= 1'b1;
    #1 d = drain_data;
    @(posedge clock);
    drain_ready <= 1'b0;
  endtask : pop
endmodule : afst_host_model

// ===== verification/afst_top_tb.sv
`timescale 1ns/1ns

module afst_top_tb;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic reg_rd, reg_wr, sample_valid = 1'b0, drain_ready, drain_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, b;
  logic [1:0] buf_mode = 2'h0;
  logic [5:0] watermark = 6'h04;
  logic [2:0] done_v = 3'h0, msb_v = 3'h0;
  logic [41:0] sample_data = 42'h0, drain_data, w;
  logic [4:0] evt_flags = 5'h00;
  logic buf_irq, buf_frozen, sample_ready;
  int errors = 0;
  int comparisons = 0;
  int seq = 1;

  always #10 clock = ~clock;

  afst_top uut (.clock(clock), .reset_n(reset_n), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .buf_mode(buf_mode), .watermark(watermark),
    .x_done(done_v[0]), .y_done(done_v[1]), .z_done(done_v[2]),
    .x_msb_read(msb_v[0]), .y_msb_read(msb_v[1]), .z_msb_read(msb_v[2]),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_data(sample_data), .evt_flags(evt_flags),
    .drain_valid(drain_valid), .drain_ready(drain_ready),
    .drain_data(drain_data), .buf_irq(buf_irq), .buf_frozen(buf_frozen));

  afst_host_model host (.clock(clock), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .drain_ready(drain_ready), .drain_data(drain_data));

  task automatic finish_test;
    $display("Comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [41:0] got, input logic [41:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic status(input logic [7:0] exp);
    host.reg_read(8'h00, b);
    chk(42'(b), 42'(exp));
  endtask : status

  // Back-to-back samples, then the last edge settles
  task automatic push(input int n);
    repeat (n) begin
      @(posedge clock);
      sample_valid <= 1'b1;
      sample_data <= 42'(seq);
      seq++;
    end
    @(posedge clock);
    sample_valid <= 1'b0;
    #1;
  endtask : push

  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    $display("Error %0t: run did not finish", $time);
    finish_test();
  end

  initial begin
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    status(8'h00);
    host.reg_read(8'h0A, b);
    chk(42'(b), 42'h00);
    host.reg_write(8'h0A, 8'h3E);
    host.reg_write(8'h0B, 8'hFF);
    host.reg_read(8'h0A, b);
    chk(42'(b), 42'h3E);
    host.reg_read(8'h55, b);
    chk(42'(b), 42'h00);
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      done_v <= 3'b001 << i;
      @(posedge clock);
      done_v <= 3'h0;
      status(8'h08 | (8'h01 << i));
      @(posedge clock);
      msb_v <= 3'b001 << i;
      @(posedge clock);
      msb_v <= 3'h0;
      status(8'h00);
    end
    buf_mode <= 2'h1;
    push(3);
    status(8'h03);
    push(1);
    chk(42'(buf_irq), 42'h1);
    status(8'h44);
    status(8'h44);
    chk(42'(buf_irq), 42'h0);
    push(28);
    chk(42'(buf_irq), 42'h1);
    status(8'h60);
    push(1);
    chk(42'(buf_irq), 42'h1);
    status(8'hE0);
    status(8'hE0);
    push(1);
    chk(42'(buf_irq), 42'h1);
    host.pop(w);
    chk(w, 42'd3);
    status(8'h5F);
    for (int k = 4; k <= 34; k++) begin
      host.pop(w);
      chk(w, 42'(k));
    end
    #1 chk(42'(drain_valid), 42'h0);
    status(8'h00);
    buf_mode <= 2'h2;
    push(33);
    status(8'hE0);
    for (int k = 35; k <= 66; k++) begin
      host.pop(w);
      chk(w, 42'(k));
    end
    buf_mode <= 2'h3;
    host.reg_write(8'h0A, 8'h20);
    push(5);
    status(8'h05);
    evt_flags <= 5'h01;
    push(1);
    status(8'h06);
    @(posedge clock);
    evt_flags <= 5'h10;
    @(posedge clock);
    #1 chk(42'(buf_frozen), 42'h1);
    chk(42'(buf_irq), 42'h1);
    push(2);
    status(8'h46);
    for (int k = 68; k <= 73; k++) begin
      host.pop(w);
      chk(w, 42'(k));
    end
    buf_mode <= 2'h0;
    evt_flags <= 5'h00;
    finish_test();
  end
endmodule : afst_top_tb
